// >>> timing_pkg.sv
package timing_pkg;

  localparam int CLOCK_WIDTH = 8;
  localparam int BUS_WIDTH = 2;
  localparam int EA_WIDTH_DEFAULT = 8;
  localparam int EA_WIDTH_MAX = 16;
  localparam int OP_COUNT = 32;
  localparam int CASE_COUNT = 3;

  // instruction groups whose timing differs; arithmetic shifts split by direction, other direction and set/clear/change variants share
  typedef enum logic [4:0] {
    DECIMAL_ADD_REG, DECIMAL_ADD_MEM, DECIMAL_SUBTRACT_REG, DECIMAL_SUBTRACT_MEM,
    EXTENDED_ADD_REG, EXTENDED_ADD_MEM, EXTENDED_SUBTRACT_REG, EXTENDED_SUBTRACT_MEM,
    COMPARE_MEM, CLEAR_OPERAND_REG, CLEAR_OPERAND_MEM, DECIMAL_NEGATE_REG,
    TEST_AND_SET_REG, TEST_AND_SET_MEM, SET_COND_REG, SET_COND_MEM,
    SIGN_EXTEND_REG, LOGICAL_SHIFT_STATIC, LOGICAL_SHIFT_DYNAMIC, LOGICAL_SHIFT_MEM,
    ARITH_LEFT_SHIFT_REG, ARITH_RIGHT_SHIFT_REG, ARITH_LEFT_SHIFT_MEM, ARITH_RIGHT_SHIFT_MEM,
    PLAIN_ROTATE_REG, PLAIN_ROTATE_MEM, EXTEND_ROTATE_REG, EXTEND_ROTATE_MEM,
    BIT_TEST_REG, BIT_TEST_MEM, BIT_SET_REG, BIT_SET_MEM
  } op_e;

  typedef enum logic [1:0] {
    CASE_BEST = 2'h0,
    CASE_CACHE = 2'h1,
    CASE_WORST = 2'h2
  } case_e;

  typedef struct packed {
    logic [CLOCK_WIDTH-1:0] clocks;
    logic [BUS_WIDTH-1:0] reads;
    logic [BUS_WIDTH-1:0] prefetches;
    logic [BUS_WIDTH-1:0] writes;
  } timing_s;

  function automatic timing_s entry(input logic [CLOCK_WIDTH-1:0] c, input logic [5:0] rpw);
    entry = '{clocks: c, reads: rpw[5:4], prefetches: rpw[3:2], writes: rpw[1:0]};
  endfunction

  // best, cache, worst; bus cycles {reads, prefetches, writes} are inside the clock count
  localparam timing_s TIMING_TABLE [OP_COUNT][CASE_COUNT] = '{
    '{entry(8'h04, 6'h00), entry(8'h04, 6'h00), entry(8'h05, 6'h04)},
    '{entry(8'h0E, 6'h21), entry(8'h10, 6'h21), entry(8'h11, 6'h25)},
    '{entry(8'h04, 6'h00), entry(8'h04, 6'h00), entry(8'h05, 6'h04)},
    '{entry(8'h0E, 6'h21), entry(8'h10, 6'h21), entry(8'h11, 6'h25)},
    '{entry(8'h02, 6'h00), entry(8'h02, 6'h00), entry(8'h03, 6'h04)},
    '{entry(8'h0A, 6'h21), entry(8'h0C, 6'h21), entry(8'h0D, 6'h25)},
    '{entry(8'h02, 6'h00), entry(8'h02, 6'h00), entry(8'h03, 6'h04)},
    '{entry(8'h0A, 6'h21), entry(8'h0C, 6'h21), entry(8'h0D, 6'h25)},
    '{entry(8'h08, 6'h20), entry(8'h09, 6'h20), entry(8'h0A, 6'h24)},
    '{entry(8'h00, 6'h00), entry(8'h02, 6'h00), entry(8'h03, 6'h04)},
    '{entry(8'h03, 6'h01), entry(8'h04, 6'h01), entry(8'h06, 6'h05)},
    '{entry(8'h06, 6'h00), entry(8'h06, 6'h00), entry(8'h06, 6'h04)},
    '{entry(8'h01, 6'h00), entry(8'h04, 6'h00), entry(8'h04, 6'h04)},
    '{entry(8'h0C, 6'h11), entry(8'h0C, 6'h11), entry(8'h0D, 6'h15)},
    '{entry(8'h01, 6'h00), entry(8'h04, 6'h00), entry(8'h04, 6'h04)},
    '{entry(8'h06, 6'h01), entry(8'h06, 6'h01), entry(8'h06, 6'h05)},
    '{entry(8'h01, 6'h00), entry(8'h04, 6'h00), entry(8'h04, 6'h04)},
    '{entry(8'h01, 6'h00), entry(8'h04, 6'h00), entry(8'h04, 6'h04)},
    '{entry(8'h03, 6'h00), entry(8'h06, 6'h00), entry(8'h06, 6'h04)},
    '{entry(8'h05, 6'h01), entry(8'h05, 6'h01), entry(8'h06, 6'h05)},
    '{entry(8'h05, 6'h00), entry(8'h08, 6'h00), entry(8'h08, 6'h04)},
    '{entry(8'h03, 6'h00), entry(8'h06, 6'h00), entry(8'h06, 6'h04)},
    '{entry(8'h06, 6'h01), entry(8'h06, 6'h01), entry(8'h07, 6'h05)},
    '{entry(8'h05, 6'h01), entry(8'h05, 6'h01), entry(8'h06, 6'h05)},
    '{entry(8'h05, 6'h00), entry(8'h08, 6'h00), entry(8'h08, 6'h04)},
    '{entry(8'h07, 6'h01), entry(8'h07, 6'h01), entry(8'h07, 6'h05)},
    '{entry(8'h09, 6'h00), entry(8'h0C, 6'h00), entry(8'h0C, 6'h04)},
    '{entry(8'h05, 6'h01), entry(8'h05, 6'h01), entry(8'h06, 6'h05)},
    '{entry(8'h01, 6'h00), entry(8'h04, 6'h00), entry(8'h05, 6'h04)},
    '{entry(8'h04, 6'h00), entry(8'h04, 6'h00), entry(8'h05, 6'h04)},
    '{entry(8'h01, 6'h00), entry(8'h04, 6'h00), entry(8'h05, 6'h04)},
    '{entry(8'h04, 6'h01), entry(8'h04, 6'h01), entry(8'h05, 6'h05)}
  };

  // one bit per op: effective address time is added on top of the listed count
  localparam logic [OP_COUNT-1:0] EA_ADDED = 32'hAAC8_A400;

endpackage

// >>> bcd_shift_bit_op_timing.sv
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Total clocks per case include its read, prefetch and write bus cycles.
// - Shift and rotate time never depends on the shift count.
// - Decimal add/subtract registers: 4, 4, 5 clocks; worst adds one prefetch.
// - Extended add/subtract registers: 2, 2, 3 clocks; worst adds one prefetch.
// - Memory compare postincrement: two reads; 8, 9, 10 clocks.
// - Clear memory: one write; 3, 4, 6 clocks; plus address time.
// - Decimal negate register: 6 clocks always; worst has one prefetch.
// - Test-and-set memory: one read, one write; 12, 12, 13 clocks.
// - Conditional byte set memory: one write; 6 clocks every case.
// - Sign extend register: 1 clock best, 4 otherwise.
// - Static logical shift register: 1 clock best, 4 otherwise.
// - Dynamic logical shift register: 3 clocks best, 6 otherwise.
// - Arithmetic shift register: left 5 best, 8 else; right 3 best, 6 else.
// - Rotate through extend register: 9 clocks best, 12 otherwise.
// - Plain rotate memory by one: one write; 7 clocks every case.
// - Bit test register: 1, 4, 5 clocks.
// - Bit test memory: no write; 4, 4, 5 clocks plus address time.
// - Bit set/clear/change memory: one write; 4, 4, 5 clocks.
// - Flagged entries add effective address fetch time to the listed count.
module bcd_shift_bit_op_timing
  import timing_pkg::*;
#(
  parameter int EA_WIDTH = EA_WIDTH_DEFAULT,
  localparam int TOTAL_WIDTH = (EA_WIDTH > CLOCK_WIDTH ? EA_WIDTH : CLOCK_WIDTH) + 1
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic start,
  input wire op_e op_code,
  input wire logic cache_hit,
  input wire logic overlapped,
  input wire logic [EA_WIDTH-1:0] ea_clocks,
  output logic ready,
  output logic busy,
  output logic done,
  output logic read_strobe,
  output logic prefetch_strobe,
  output logic write_strobe,
  output case_e case_used,
  output logic [TOTAL_WIDTH-1:0] total_clocks,
  output logic [BUS_WIDTH-1:0] read_count,
  output logic [BUS_WIDTH-1:0] prefetch_count,
  output logic [BUS_WIDTH-1:0] write_count
);

  if (EA_WIDTH < 1 || EA_WIDTH > EA_WIDTH_MAX) begin : g_bad_width
    $error("EA_WIDTH out of range");
  end

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } state_e;

  typedef logic [TOTAL_WIDTH-1:0] count_t;

  state_e state;
  count_t elapsed;
  count_t ea_base;
  count_t next_total;
  count_t next_ea;
  case_e next_case;
  timing_s sel;
  logic accept;
  logic last_cycle;

  // overlap only helps when the next opcode is already in the cache
  function automatic case_e pick_case(input logic hit, input logic overlap);
    if (!hit) begin
      pick_case = CASE_WORST;
    end else if (overlap) begin
      pick_case = CASE_BEST;
    end else begin
      pick_case = CASE_CACHE;
    end
  endfunction

  // reads follow the address time, write lands just ahead of the trailing prefetch
  function automatic logic [2:0] bus_kind(input count_t k, input count_t base,
                                          input count_t total, input logic [BUS_WIDTH-1:0] r,
                                          input logic [BUS_WIDTH-1:0] p,
                                          input logic [BUS_WIDTH-1:0] w);
    logic rd;
    logic pf;
    logic wr;
    rd = (k >= base) && ((k - base) < count_t'(r));
    pf = (p != '0) && (k == total - count_t'(1));
    wr = (w != '0) && (k == total - count_t'(1) - count_t'(p));
    bus_kind = {rd, pf, wr};
  endfunction

  always_comb begin
    next_case = pick_case(cache_hit, overlapped);
    // table lookup ignores any shift count, so timing is count independent
    sel = TIMING_TABLE[op_code][next_case];
    next_ea = EA_ADDED[op_code] ? count_t'(ea_clocks) : '0;
    next_total = count_t'(sel.clocks) + next_ea;
  end

  assign accept = (state == ST_IDLE) && start;
  assign last_cycle = (state == ST_EXEC) && (elapsed == total_clocks - count_t'(1));

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= ST_IDLE;
      ready <= 1'b1;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          done <= 1'b0;
          if (start) begin
            // zero-clock entries finish at once, fully overlapped
            if (next_total == '0) begin
              done <= 1'b1;
            end else begin
              state <= ST_EXEC;
              ready <= 1'b0;
              busy <= 1'b1;
            end
          end
        end
        ST_EXEC: begin
          if (last_cycle) begin
            state <= ST_IDLE;
            ready <= 1'b1;
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      elapsed <= '0;
    end else if (accept) begin
      elapsed <= '0;
    end else if (state == ST_EXEC) begin
      elapsed <= elapsed + count_t'(1);
    end
  end

  // latched operation figures stay visible until the next accept
  always_ff @(posedge core_clk) begin
    if (reset) begin
      total_clocks <= '0;
      ea_base <= '0;
      case_used <= CASE_BEST;
      read_count <= '0;
      prefetch_count <= '0;
      write_count <= '0;
    end else if (accept) begin
      total_clocks <= next_total;
      ea_base <= next_ea;
      case_used <= next_case;
      read_count <= sel.reads;
      prefetch_count <= sel.prefetches;
      write_count <= sel.writes;
    end
  end

  // bus strobes are placed inside the counted clocks, never beyond them
  always_ff @(posedge core_clk) begin
    if (reset) begin
      {read_strobe, prefetch_strobe, write_strobe} <= 3'h0;
    end else if (accept && next_total != '0) begin
      {read_strobe, prefetch_strobe, write_strobe} <=
        bus_kind('0, next_ea, next_total, sel.reads, sel.prefetches, sel.writes);
    end else if (state == ST_EXEC && !last_cycle) begin
      {read_strobe, prefetch_strobe, write_strobe} <=
        bus_kind(elapsed + count_t'(1), ea_base, total_clocks, read_count,
                 prefetch_count, write_count);
    end else begin
      {read_strobe, prefetch_strobe, write_strobe} <= 3'h0;
    end
  end

  // per-op figures live in TIMING_TABLE rows:
  // decimal add/subtract register rows
  // extended add/subtract register rows
  // memory compare row
  // clear memory row with address time
  // decimal negate row
  // test-and-set memory row
  // conditional set memory row
  // sign extend row
  // static logical shift row
  // dynamic logical shift row
  // arithmetic shift rows
  // extend rotate register row
  // plain rotate memory row
  // bit test register row
  // bit test memory row
  // bit set memory row

endmodule
`default_nettype wire

// >>> op_timing_properties.sv
`timescale 1ns/1ns
`default_nettype none
module op_timing_checker
  import timing_pkg::*;
#(
  parameter int EA_WIDTH = EA_WIDTH_DEFAULT,
  localparam int TW = (EA_WIDTH > CLOCK_WIDTH ? EA_WIDTH : CLOCK_WIDTH) + 1
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic start,
  input wire op_e op_code,
  input wire logic cache_hit,
  input wire logic overlapped,
  input wire logic [EA_WIDTH-1:0] ea_clocks,
  input wire logic ready,
  input wire logic busy,
  input wire logic done,
  input wire logic prefetch_strobe,
  input wire logic write_strobe,
  input wire case_e case_used,
  input wire logic [TW-1:0] total_clocks,
  input wire logic [BUS_WIDTH-1:0] read_count,
  input wire logic [BUS_WIDTH-1:0] write_count
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_take;
    start && ready;
  endsequence
  sequence s_last;
    busy ##1 (done && !busy);
  endsequence
  // zero-clock entries finish at once, so ready may stay up with done
  a_take_leaves_idle: assert property (s_take |=> (!ready || done))
    else $error("ready stayed high after accept");
  a_miss_picks_worst: assert property (s_take ##0 !cache_hit |=> case_used == CASE_WORST)
    else $error("miss did not pick worst case");
  a_overlap_picks_best:
    assert property (s_take ##0 (cache_hit && overlapped) |=> case_used == CASE_BEST)
    else $error("overlapped hit did not pick best case");
  a_hit_picks_cache:
    assert property (s_take ##0 (cache_hit && !overlapped) |=> case_used == CASE_CACHE)
    else $error("plain hit did not pick cache case");
  a_tas_adds_ea:
    assert property (s_take ##0 (op_code == TEST_AND_SET_MEM && !cache_hit)
    |=> total_clocks == 13 + $past(ea_clocks))
    else $error("test-and-set worst total wrong");
  a_decimal_no_ea:
    assert property (s_take ##0 (op_code == DECIMAL_ADD_REG && cache_hit)
    |=> total_clocks == 4)
    else $error("decimal add register total wrong");
  a_compare_two_reads:
    assert property (s_take ##0 op_code == COMPARE_MEM
    |=> read_count == 2 && write_count == 0)
    else $error("memory compare bus counts wrong");
  a_prefetch_at_end: assert property (prefetch_strobe |-> s_last)
    else $error("prefetch not in last busy cycle");
  a_done_follows_busy: assert property ($fell(busy) |-> done)
    else $error("done missing after busy");
  a_write_inside_busy: assert property (write_strobe |-> busy)
    else $error("write outside execution");
endmodule
bind bcd_shift_bit_op_timing op_timing_checker #(.EA_WIDTH(EA_WIDTH)) chk (.core_clk, .reset,
  .start, .op_code, .cache_hit, .overlapped, .ea_clocks, .ready, .busy, .done,
  .prefetch_strobe, .write_strobe, .case_used, .total_clocks, .read_count, .write_count);
`default_nettype wire

// >>> mem_bus_model.sv
`timescale 1ns/1ns
`default_nettype none
module mem_bus_model (
  input wire logic core_clk,
  input wire logic start,
  input wire logic ready,
  input wire logic busy,
  input wire logic read_strobe,
  input wire logic prefetch_strobe,
  input wire logic write_strobe,
  output int n_busy,
  output int n_rd,
  output int n_pf,
  output int n_wr
);
  // tallies one operation's bus cycles, cleared as the next is taken
  always @(posedge core_clk) begin
    n_busy <= (start && ready) ? 0 : n_busy + busy;
    n_rd <= (start && ready) ? 0 : n_rd + read_strobe;
    n_pf <= (start && ready) ? 0 : n_pf + prefetch_strobe;
    n_wr <= (start && ready) ? 0 : n_wr + write_strobe;
  end
endmodule
`default_nettype wire

// >>> bcd_shift_bit_op_timing_tb.sv
`timescale 1ns/1ns
`default_nettype none
module bcd_shift_bit_op_timing_tb;
  import timing_pkg::*;
  logic core_clk = 0, reset = 1, start = 0, cache_hit = 0, overlapped = 0;
  op_e op_code = DECIMAL_ADD_REG;
  logic [7:0] ea_clocks = 8'h00;
  logic ready, busy, done, rd, pf, wr;
  case_e case_used;
  logic [8:0] total_clocks;
  logic [1:0] read_count, prefetch_count, write_count;
  int n_busy, n_rd, n_pf, n_wr, failures = 0, n_checks = 0;
  op_e ops [7] = '{DECIMAL_ADD_REG, COMPARE_MEM, TEST_AND_SET_MEM, DECIMAL_NEGATE_REG,
    EXTEND_ROTATE_REG, BIT_SET_MEM, SIGN_EXTEND_REG};
  always #25 core_clk = ~core_clk;
  bcd_shift_bit_op_timing dut (.core_clk, .reset, .start, .op_code, .cache_hit, .overlapped,
    .ea_clocks, .ready, .busy, .done, .read_strobe(rd), .prefetch_strobe(pf),
    .write_strobe(wr), .case_used, .total_clocks, .read_count, .prefetch_count, .write_count);
  mem_bus_model bus (.core_clk, .start, .ready, .busy, .read_strobe(rd),
    .prefetch_strobe(pf), .write_strobe(wr), .n_busy, .n_rd, .n_pf, .n_wr);
  task automatic check(logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  function automatic int exp_clk(op_e op, case_e c);
    case (op)
      DECIMAL_ADD_REG: return c == CASE_WORST ? 5 : 4;
      COMPARE_MEM: return 8 + int'(c);
      TEST_AND_SET_MEM: return c == CASE_WORST ? 13 : 12;
      DECIMAL_NEGATE_REG: return 6;
      EXTEND_ROTATE_REG: return c == CASE_BEST ? 9 : 12;
      BIT_SET_MEM: return c == CASE_WORST ? 5 : 4;
      default: return c == CASE_BEST ? 1 : 4;
    endcase
  endfunction
  task automatic run_op(op_e op, logic hit, logic ovl, logic [7:0] ea);
    case_e c;
    int n, r, w, i;
    logic fl;
    c = !hit ? CASE_WORST : (ovl ? CASE_BEST : CASE_CACHE);
    fl = op == TEST_AND_SET_MEM || op == BIT_SET_MEM;
    n = exp_clk(op, c) + (fl ? ea : 0);
    r = op == COMPARE_MEM ? 2 : (op == TEST_AND_SET_MEM ? 1 : 0);
    w = fl ? 1 : 0;
    op_code = op;
    cache_hit = hit;
    overlapped = ovl;
    ea_clocks = ea;
    start = 1;
    @(posedge core_clk) #2;
    // a second request while busy must be ignored
    op_code = BIT_TEST_MEM;
    @(posedge core_clk) #2;
    start = 0;
    for (i = 1; i < 300 && done !== 1'b1; i++) @(posedge core_clk) #2;
    // done shows n edges after the accepting edge
    check(i, n);
    check(n_busy, n);
    check(total_clocks, n);
    check(case_used, c);
    check(n_rd, r);
    check(n_pf, c == CASE_WORST);
    check(n_wr, w);
    check({read_count, prefetch_count, write_count}, {2'(r), 2'(c == CASE_WORST), 2'(w)});
    $display("test done: op %0d case %0d", op, c);
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #1000000;
    failures++;
    conclude();
  end
  initial begin
    void'($urandom(32'h943a));
    repeat (16) @(posedge core_clk);
    #2 reset = 0;
    check(ready, 1'b1);
    for (int k = 0; k < 21; k++) run_op(ops[k / 3], k % 3 != 2, k % 3 == 0, 8'h03);
    run_op(TEST_AND_SET_MEM, 0, 0, 8'hFF);
    run_op(BIT_SET_MEM, 1, 1, 8'h00);
    for (int k = 0; k < 40; k++) run_op(ops[$urandom % 7], $urandom, $urandom, $urandom % 16);
    conclude();
  end
endmodule
`default_nettype wire
